/* uhise_defines.svh */
// register offsets, field positions, reset values for the event flag block
// assumes byte offsets relative to the controller's register base
`ifndef UHISE_DEFINES_SVH
`define UHISE_DEFINES_SVH

// ************************************************************
// register offsets
// ************************************************************
`define UHISE_OFS_EVENT_FLAGS 8'h0C
`define UHISE_OFS_SOURCE_ENABLES 8'h10

// ************************************************************
// field positions
// ************************************************************
`define UHISE_BIT_OVERRUN 0
`define UHISE_BIT_DONE_HEAD 1
`define UHISE_BIT_SOF 2
`define UHISE_BIT_RESUME 3
`define UHISE_BIT_UNRECOV 4
`define UHISE_BIT_FRAME_OVF 5
`define UHISE_BIT_ROOT_HUB 6
`define UHISE_BIT_OWNERSHIP 30
`define UHISE_BIT_MASTER 31
`define UHISE_FRAME_MSB 15

// ************************************************************
// masks and reset values
// ************************************************************
`define UHISE_FLAG_MASK 32'h4000007F
`define UHISE_ENABLE_MASK 32'hC000007F
`define UHISE_FLAGS_RESET 32'h00000000
`define UHISE_ENABLES_RESET 32'h00000000
`define UHISE_COUNT_RESET 2'h0
`define UHISE_COUNT_STEP 2'h1
`define UHISE_SMI_PRESENT 1'h1

`endif

/* uhise_pkg.sv */
// types shared by the event flag block
// assumes nothing beyond the defines header
package uhise_pkg;

  // ************************************************************
  // types
  // ************************************************************
  typedef logic [31:0] uhise_word_t;
  typedef logic [7:0] uhise_addr_t;
  typedef logic [1:0] uhise_count_t;

endpackage : uhise_pkg

/* uhise_flag_bank.sv */
// bank of sticky flags: hardware sets, writer clears, set wins
// assumes single clock, synchronous active-low reset plus soft reset
`timescale 1ns/1ps
module uhise_flag_bank (
  clk,
  rst_b,
  soft_clear,
  set_vec,
  clear_vec,
  flags
);
  input wire logic clk;
  input wire logic rst_b;
  input wire logic soft_clear;
  input wire uhise_pkg::uhise_word_t set_vec;
  input wire uhise_pkg::uhise_word_t clear_vec;
  output uhise_pkg::uhise_word_t flags;

  uhise_pkg::uhise_word_t flags_r;

  // ************************************************************
  // one sticky cell per bit
  // ************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi = gi + 1) begin : g_cell
      // a set in the clearing cycle is kept
      always_ff @(posedge clk) begin
        if (!rst_b || soft_clear) begin
          flags_r[gi] <= 1'h0;
        end else if (set_vec[gi]) begin
          flags_r[gi] <= 1'h1;
        end else if (clear_vec[gi]) begin
          flags_r[gi] <= 1'h0;
        end
      end
    end
  endgenerate

  assign flags = flags_r;

endmodule : uhise_flag_bank

/* uhise_core.sv */
// interrupt event flags and source enables of a usb host controller function
// assumes event inputs are one-cycle pulses synchronous to clk
// assumes a simple register port: strobes, byte offset, read data one cycle later
//
// Notes on behaviour
// - ownership request sets ownership flag bit 30
// - unmasked ownership event raises management interrupt
// - no management pin means ownership flag zero
// - root hub register change sets bit 6
// - frame msb toggle or copy update sets 5
// - system error sets unrecoverable flag bit 4
// - after system error halt schedule and signalling
// - device resume signalling start sets bit 3
// - software resume entry never sets resume flag
// - start of frame sets bit 2 with token
// - done head write-back sets bit 1
// - no new write-back until bit 1 cleared
// - schedule overrun after copy update sets bit 0
// - each overrun increments two-bit counter
// - irq needs flag, its enable, master enable
// - enables are write-one-to-set, readable
// - master enable bit 31 gates host irq only, not management interrupt
// - enables mirror flag positions, reset zero
// - flags write-one-to-clear, hardware never clears
// - counter resets zero, wraps, counts always
`timescale 1ns/1ps
`include "uhise_defines.svh"
module uhise_core (
  clk,
  rst_b,
  soft_reset,
  reg_wr_en,
  reg_rd_en,
  reg_addr,
  reg_wdata,
  reg_rdata,
  reg_rd_valid,
  ownership_change_request,
  root_hub_status_changed,
  frame_number_counter,
  frame_copy_updated,
  system_error,
  error_corrected,
  resume_signalling,
  sw_resume_entry,
  sof_token_issue,
  done_head_written,
  schedule_overrun,
  host_irq,
  system_management_irq_pin,
  processing_halted,
  done_head_write_allowed,
  overrun_count
);
  input wire logic clk;
  input wire logic rst_b;
  input wire logic soft_reset;
  input wire logic reg_wr_en;
  input wire logic reg_rd_en;
  input wire uhise_pkg::uhise_addr_t reg_addr;
  input wire uhise_pkg::uhise_word_t reg_wdata;
  output uhise_pkg::uhise_word_t reg_rdata;
  output logic reg_rd_valid;
  input wire logic ownership_change_request;
  input wire logic root_hub_status_changed;
  input wire logic [15:0] frame_number_counter;
  input wire logic frame_copy_updated;
  input wire logic system_error;
  input wire logic error_corrected;
  input wire logic resume_signalling;
  input wire logic sw_resume_entry;
  input wire logic sof_token_issue;
  input wire logic done_head_written;
  input wire logic schedule_overrun;
  output logic host_irq;
  output logic system_management_irq_pin;
  output logic processing_halted;
  output logic done_head_write_allowed;
  output uhise_pkg::uhise_count_t overrun_count;

  // ************************************************************
  // state
  // ************************************************************
  uhise_pkg::uhise_word_t enables_r;
  uhise_pkg::uhise_word_t flags;
  uhise_pkg::uhise_word_t set_vec;
  uhise_pkg::uhise_word_t clear_vec;
  uhise_pkg::uhise_word_t rdata_nxt;
  uhise_pkg::uhise_word_t reg_rdata_r;
  uhise_pkg::uhise_count_t overrun_count_r;
  logic reg_rd_valid_r;
  logic frame_msb_r;
  logic resume_prev_r;
  logic halted_r;
  logic host_irq_r;
  logic smi_r;
  logic write_allowed_r;
  logic wr_flags;
  logic wr_enables;
  logic rd_flags;
  logic rd_enables;
  logic any_reset;
  logic resume_rise;
  logic frame_toggle;

  // ************************************************************
  // register decode
  // ************************************************************
  assign any_reset = !rst_b || soft_reset;
  assign wr_flags = reg_wr_en && (reg_addr == `UHISE_OFS_EVENT_FLAGS);
  assign wr_enables = reg_wr_en && (reg_addr == `UHISE_OFS_SOURCE_ENABLES);
  assign rd_flags = reg_addr == `UHISE_OFS_EVENT_FLAGS;
  assign rd_enables = reg_addr == `UHISE_OFS_SOURCE_ENABLES;

  // ************************************************************
  // event detection
  // ************************************************************
  // remembered frame msb and resume level for change detection
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      frame_msb_r <= 1'h0;
      resume_prev_r <= 1'h0;
    end else begin
      frame_msb_r <= frame_number_counter[`UHISE_FRAME_MSB];
      resume_prev_r <= resume_signalling;
    end
  end

  assign frame_toggle = frame_msb_r != frame_number_counter[`UHISE_FRAME_MSB];
  // only device-driven resume edges count, never software entry
  assign resume_rise = resume_signalling && !resume_prev_r && !sw_resume_entry;

  // set vector: one bit per event source
  always_comb begin
    set_vec = 32'h00000000;
    set_vec[`UHISE_BIT_OWNERSHIP] = ownership_change_request && `UHISE_SMI_PRESENT;
    set_vec[`UHISE_BIT_ROOT_HUB] = root_hub_status_changed;
    set_vec[`UHISE_BIT_FRAME_OVF] = frame_toggle || frame_copy_updated;
    set_vec[`UHISE_BIT_UNRECOV] = system_error;
    set_vec[`UHISE_BIT_RESUME] = resume_rise;
    set_vec[`UHISE_BIT_SOF] = sof_token_issue;
    set_vec[`UHISE_BIT_DONE_HEAD] = done_head_written;
    set_vec[`UHISE_BIT_OVERRUN] = schedule_overrun;
  end

  // ones written to the flag register clear, zeros do nothing
  always_comb begin
    clear_vec = 32'h00000000;
    if (wr_flags) begin
      clear_vec = reg_wdata & `UHISE_FLAG_MASK;
    end
  end

  // ************************************************************
  // sticky event flags
  // ************************************************************
  uhise_flag_bank u_flags (
    .clk(clk),
    .rst_b(rst_b),
    .soft_clear(soft_reset),
    .set_vec(set_vec & `UHISE_FLAG_MASK),
    .clear_vec(clear_vec),
    .flags(flags)
  );

  // ************************************************************
  // source enables
  // ************************************************************
  // ones written set enables, zeros leave them, reserved stay zero
  always_ff @(posedge clk) begin
    if (any_reset) begin
      enables_r <= `UHISE_ENABLES_RESET;
    end else if (wr_enables) begin
      enables_r <= enables_r | (reg_wdata & `UHISE_ENABLE_MASK);
    end
  end

  // ************************************************************
  // overrun counter
  // ************************************************************
  // counts every overrun whether or not its flag is already set
  always_ff @(posedge clk) begin
    if (any_reset) begin
      overrun_count_r <= `UHISE_COUNT_RESET;
    end else if (schedule_overrun) begin
      overrun_count_r <= overrun_count_r + `UHISE_COUNT_STEP;
    end
  end

  // ************************************************************
  // error halt
  // ************************************************************
  // processing stays stopped until the error is corrected or reset
  always_ff @(posedge clk) begin
    if (any_reset) begin
      halted_r <= 1'h0;
    end else if (system_error) begin
      halted_r <= 1'h1;
    end else if (error_corrected) begin
      halted_r <= 1'h0;
    end
  end

  // ************************************************************
  // done head write-back gate
  // ************************************************************
  // next write-back waits for the flag to be cleared by software
  always_ff @(posedge clk) begin
    if (any_reset) begin
      write_allowed_r <= 1'h1;
    end else begin
      write_allowed_r <= !(set_vec[`UHISE_BIT_DONE_HEAD]
        || (flags[`UHISE_BIT_DONE_HEAD] && !clear_vec[`UHISE_BIT_DONE_HEAD]));
    end
  end

  // ************************************************************
  // interrupt outputs
  // ************************************************************
  // level request while any enabled flag is set under master enable
  always_ff @(posedge clk) begin
    if (any_reset) begin
      host_irq_r <= 1'h0;
    end else begin
      host_irq_r <= enables_r[`UHISE_BIT_MASTER]
        && |(flags & enables_r & `UHISE_FLAG_MASK);
    end
  end

  // management interrupt follows the unmasked ownership flag
  always_ff @(posedge clk) begin
    if (any_reset) begin
      smi_r <= 1'h0;
    end else begin
      smi_r <= `UHISE_SMI_PRESENT && flags[`UHISE_BIT_OWNERSHIP]
        && enables_r[`UHISE_BIT_OWNERSHIP];
    end
  end

  // ************************************************************
  // register reads
  // ************************************************************
  // unmapped offsets read as zero
  always_comb begin
    rdata_nxt = 32'h00000000;
    if (rd_flags) begin
      rdata_nxt = flags;
    end else if (rd_enables) begin
      rdata_nxt = enables_r;
    end
  end

  // read data and its valid strobe one cycle after the request
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      reg_rdata_r <= 32'h00000000;
      reg_rd_valid_r <= 1'h0;
    end else begin
      reg_rd_valid_r <= reg_rd_en;
      if (reg_rd_en) begin
        reg_rdata_r <= rdata_nxt;
      end
    end
  end

  assign reg_rdata = reg_rdata_r;
  assign reg_rd_valid = reg_rd_valid_r;
  assign host_irq = host_irq_r;
  assign system_management_irq_pin = smi_r;
  assign processing_halted = halted_r;
  assign done_head_write_allowed = write_allowed_r;
  assign overrun_count = overrun_count_r;

endmodule : uhise_core

/* uhise_checker.sv */
// checker: port-level assertions for the event flag block
// assumes it is bound to uhise_core; one clock, rst_b low means reset
`timescale 1ns/1ps
`include "uhise_defines.svh"
module uhise_checker (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic soft_reset,
  input wire logic reg_rd_en,
  input wire uhise_pkg::uhise_addr_t reg_addr,
  input wire uhise_pkg::uhise_word_t reg_rdata,
  input wire logic reg_rd_valid,
  input wire logic system_error,
  input wire logic error_corrected,
  input wire logic done_head_written,
  input wire logic schedule_overrun,
  input wire logic host_irq,
  input wire logic system_management_irq_pin,
  input wire logic processing_halted,
  input wire logic done_head_write_allowed,
  input wire uhise_pkg::uhise_count_t overrun_count
);
  // ********
  // assertions
  // ********
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  chk_count_step: assert property (
    schedule_overrun && !soft_reset |=> overrun_count == $past(overrun_count) + 2'h1)
    else $error("overrun count did not step");
  chk_count_hold: assert property (
    !schedule_overrun && !soft_reset |=> $stable(overrun_count))
    else $error("overrun count moved without overrun");
  chk_halt_set: assert property (
    system_error && !soft_reset && !error_corrected |=> processing_halted)
    else $error("no halt after system error");
  chk_halt_hold: assert property (
    !system_error && !error_corrected && !soft_reset |=> $stable(processing_halted))
    else $error("halt changed without cause");
  chk_done_block: assert property (
    done_head_written && !soft_reset |=> ##[0:1] !done_head_write_allowed)
    else $error("write-back still allowed");
  chk_valid_lag: assert property (
    1'h1 |=> reg_rd_valid == $past(reg_rd_en))
    else $error("read valid not one cycle after strobe");
  chk_soft_clear: assert property (
    soft_reset |=> !host_irq && !system_management_irq_pin && overrun_count == 2'h0)
    else $error("outputs not cleared by soft reset");
  chk_reserved_zero: assert property (
    reg_rd_en |=> (reg_rdata & ~`UHISE_ENABLE_MASK) == 32'h0)
    else $error("reserved bits read nonzero");
  chk_unmapped_zero: assert property (
    reg_rd_en && reg_addr != `UHISE_OFS_EVENT_FLAGS && reg_addr != `UHISE_OFS_SOURCE_ENABLES
    |=> reg_rdata == 32'h0)
    else $error("unmapped read nonzero");
  cover property (schedule_overrun && overrun_count == 2'h3);
  cover property (processing_halted && error_corrected);
  cover property (host_irq && system_management_irq_pin);
endmodule : uhise_checker

/* uhise_host_drv.sv */
// host driver model: register writes and reads on the block port
// assumes calls start 1 ns after a rising edge of clk
`timescale 1ns/1ps
module uhise_host_drv (
  input wire logic clk,
  output logic reg_wr_en,
  output logic reg_rd_en,
  output uhise_pkg::uhise_addr_t reg_addr,
  output uhise_pkg::uhise_word_t reg_wdata,
  input wire uhise_pkg::uhise_word_t reg_rdata,
  input wire logic reg_rd_valid
);
  // idle port at time zero
  initial begin
    reg_wr_en = 1'h0;
    reg_rd_en = 1'h0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
  end
  // one write, taken at the next edge; idle lines then show inverted junk
  task automatic wr(uhise_pkg::uhise_addr_t a, uhise_pkg::uhise_word_t v);
    reg_wr_en = 1'h1;
    reg_addr = a;
    reg_wdata = v;
    @(posedge clk);
    #1;
    reg_wr_en = 1'h0;
    reg_addr = ~reg_addr;
    reg_wdata = ~reg_wdata;
    @(posedge clk);
    #1;
  endtask : wr
  // one read; data only counts with valid, else unknown
  task automatic rd(uhise_pkg::uhise_addr_t a, output uhise_pkg::uhise_word_t v);
    reg_rd_en = 1'h1;
    reg_addr = a;
    @(posedge clk);
    #1;
    v = reg_rd_valid === 1'h1 ? reg_rdata : 32'hX;
    reg_rd_en = 1'h0;
    reg_addr = ~reg_addr;
    @(posedge clk);
    #1;
  endtask : rd
endmodule : uhise_host_drv

/* testbench.sv */
// self-checking bench for the event flag block
// assumes design, host driver model and checker are compiled first
`timescale 1ns/1ps
`include "uhise_defines.svh"
module testbench;
  logic clk = 1'h0;
  logic rst_b = 1'h0;
  logic soft_reset = 1'h0;
  logic [8:0] ev = 9'h000;
  logic [15:0] frame_number_counter = 16'h0000;
  logic sw_resume_entry = 1'h0;
  logic reg_wr_en, reg_rd_en, reg_rd_valid;
  logic host_irq, system_management_irq_pin, processing_halted, done_head_write_allowed;
  uhise_pkg::uhise_addr_t reg_addr;
  uhise_pkg::uhise_word_t reg_wdata, reg_rdata, d, en;
  uhise_pkg::uhise_count_t overrun_count, exp_cnt;
  wire [2:0] side_st = {system_management_irq_pin, processing_halted, done_head_write_allowed};
  int err_total = 0;
  int tests_run = 0;
  int cycles = 0;
  localparam logic [7:0] FL = `UHISE_OFS_EVENT_FLAGS;
  localparam logic [7:0] EN = `UHISE_OFS_SOURCE_ENABLES;
  uhise_host_drv i_uhise_host_drv (.*);
  uhise_core i_uhise_core (
    .*,
    .ownership_change_request(ev[7]),
    .root_hub_status_changed(ev[6]),
    .frame_copy_updated(ev[5]),
    .system_error(ev[4]),
    .resume_signalling(ev[3]),
    .sof_token_issue(ev[2]),
    .done_head_written(ev[1]),
    .schedule_overrun(ev[0]),
    .error_corrected(ev[8])
  );
  // 50 ns clock and hang guard
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_total = err_total + 1;
      tally_and_finish();
    end
  end
  // ********
  // helpers
  // ********
  task automatic chk(uhise_pkg::uhise_word_t seen, uhise_pkg::uhise_word_t exp);
    tests_run = tests_run + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic fire(int i);
    ev[i] = 1'h1;
    tick(1);
    ev[i] = 1'h0;
    if (i == 0) exp_cnt = exp_cnt + 2'h1;
  endtask : fire
  task automatic xreg(uhise_pkg::uhise_addr_t a, uhise_pkg::uhise_word_t e);
    i_uhise_host_drv.rd(a, d);
    chk(d, e);
  endtask : xreg
  function automatic uhise_pkg::uhise_word_t fbit(int i);
    return i == 7 ? 32'h40000000 : 32'h1 << i;
  endfunction : fbit
  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish
  // ********
  // test sequence
  // ********
  initial begin
    void'($urandom(84170));
    exp_cnt = 2'h0;
    tick(5);
    rst_b = 1'h1;
    xreg(FL, 32'h0);
    xreg(EN, 32'h0);
    chk({29'h0, side_st}, 32'h1);
    $display("reset values done");
    en = ($urandom() & 32'h4000007F) | 32'h1;
    i_uhise_host_drv.wr(EN, en);
    i_uhise_host_drv.wr(EN, 32'h0);
    i_uhise_host_drv.wr(EN, 32'h3FFFFF80);
    i_uhise_host_drv.wr(8'h20, 32'hFFFFFFFF);
    xreg(EN, en);
    xreg(8'h20, 32'h0);
    i_uhise_host_drv.wr(EN, 32'h4000007F);
    fire(0);
    tick(2);
    chk({31'h0, host_irq}, 32'h0);
    i_uhise_host_drv.wr(EN, 32'h80000000);
    xreg(EN, 32'hC000007F);
    chk({31'h0, host_irq}, 32'h1);
    i_uhise_host_drv.wr(FL, 32'h1);
    xreg(FL, 32'h0);
    chk({31'h0, host_irq}, 32'h0);
    $display("enables and master gate done");
    for (int i = 0; i < 8; i++) begin
      fire(i);
      xreg(FL, fbit(i));
      chk({31'h0, host_irq}, 32'h1);
      chk({29'h0, side_st}, {29'h0, i == 7, i == 4, i != 1});
      i_uhise_host_drv.wr(FL, 32'h0);
      xreg(FL, fbit(i));
      if (i == 4) begin
        // correct the error, then reset the controller before clearing the flag
        fire(8);
        chk({31'h0, processing_halted}, 32'h0);
        soft_reset = 1'h1;
        tick(1);
        soft_reset = 1'h0;
        exp_cnt = 2'h0;
        chk({30'h0, overrun_count}, {30'h0, exp_cnt});
        i_uhise_host_drv.wr(EN, 32'hC000007F);
      end
      i_uhise_host_drv.wr(FL, fbit(i));
      xreg(FL, 32'h0);
      chk({28'h0, host_irq, side_st}, 32'h1);
    end
    $display("event sources done");
    ev[0] = 1'h1;
    tick(5);
    ev[0] = 1'h0;
    repeat (5) exp_cnt = exp_cnt + 2'h1;
    tick(1);
    chk({30'h0, overrun_count}, {30'h0, exp_cnt});
    i_uhise_host_drv.wr(FL, 32'h1);
    $display("overrun count done");
    sw_resume_entry = 1'h1;
    tick(1);
    ev[3] = 1'h1;
    tick(1);
    ev[3] = 1'h0;
    sw_resume_entry = 1'h0;
    xreg(FL, 32'h0);
    frame_number_counter[14:0] = 15'($urandom());
    xreg(FL, 32'h0);
    frame_number_counter[15] = 1'h1;
    tick(1);
    xreg(FL, 32'h20);
    $display("resume and frame done");
    fire(4);
    soft_reset = 1'h1;
    tick(1);
    soft_reset = 1'h0;
    xreg(FL, 32'h0);
    xreg(EN, 32'h0);
    chk({27'h0, overrun_count, side_st}, 32'h1);
    $display("soft reset done");
    tally_and_finish();
  end
endmodule : testbench
bind uhise_core uhise_checker i_uhise_checker (.*);
